// ===== common/flash_pkg.sv
package flash_pkg;
    // opcodes
    localparam logic [7:0] OP_WREN = 8'h06, OP_VWREN = 8'h50, OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR1 = 8'h05, OP_RDSR2 = 8'h35, OP_RDSR3 = 8'h15;
    localparam logic [7:0] OP_WRSR1 = 8'h01, OP_WRSR2 = 8'h31, OP_WRSR3 = 8'h11;
    localparam logic [7:0] OP_READ = 8'h03, OP_FREAD = 8'h0b, OP_DREAD = 8'h3b;
    localparam logic [7:0] OP_QREAD = 8'h6b, OP_DIO = 8'hbb, OP_QIO = 8'heb;
    localparam logic [7:0] OP_PP = 8'h02, OP_SE = 8'h20, OP_BE32 = 8'h52, OP_BE64 = 8'hd8;
    localparam logic [7:0] OP_CE1 = 8'hc7, OP_CE2 = 8'h60, OP_DPD = 8'hb9, OP_RDPD = 8'hab;
    localparam logic [7:0] OP_SUSP = 8'h75, OP_RESM = 8'h7a, OP_RSTEN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99, OP_TABLE = 8'h5a;
    // status bit positions
    localparam int ST_SRP_LO = 7, ST_BP_LO = 2, ST_SRP_HI = 8, ST_QE = 9;
    localparam int ST_LOCK_LO = 11, ST_CMP = 14, ST_DC = 16, ST_DRV_LO = 21;
    localparam logic [1:0] DRV_RESET = 2'h2;
    localparam logic [1:0] SRP_SOFT = 2'h0, SRP_HW = 2'h1, SRP_LOCKDOWN = 2'h2;
    // clock counts of the command phases
    localparam logic [4:0] ADDR_CLKS = 5'h18, DIO_ADDR_CLKS = 5'h0c, QIO_ADDR_CLKS = 5'h06;
    localparam logic [4:0] DUMMY_BYTE_CLKS = 5'h08, ID_DUMMY_CLKS = 5'h18;
    localparam logic [4:0] DIO_DUMMY_LO = 5'h04, DIO_DUMMY_HI = 5'h08;
    localparam logic [4:0] QIO_DUMMY_LO = 5'h06, QIO_DUMMY_HI = 5'h0a;
    localparam logic [4:0] DIN_BITS_ONE = 5'h08, DIN_BITS_TWO = 5'h10;
    // internal write cycle length, stands in for the array timing
    localparam logic [7:0] BUSY_CYCLES = 8'h40;
    localparam logic [1:0] K_WRSR = 2'h0, K_PROG = 2'h1, K_ERASE = 2'h2;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] DEVICE_ID = 8'h5c; // arbitrary value
    // host serial clock: derived from sys clock by a divider
    localparam int SYS_CLK_MHZ = 100;
    localparam int SCLK_PERIOD_NS = 160;
    localparam logic [3:0] SCLK_HALF = 4'(SCLK_PERIOD_NS * SYS_CLK_MHZ / 2000);
    // host registers
    localparam logic [3:0] REG_CTRL = 4'h0, REG_TX = 4'h4, REG_RX = 4'h8, REG_STAT = 4'hc;
    localparam int CF_TXB = 0, CF_RXB = 2, CF_DUM = 5, CF_AW = 9, CF_DW = 11;
    localparam int CF_XTRA = 13, CF_GO = 16;
endpackage : flash_pkg

// ===== common/flash_link_if.sv
`timescale 1ns/1ps
interface flash_link_if;
    logic cs_n;
    logic sclk;
    logic [3:0] host_io_out;
    logic [3:0] host_io_oe;
    logic [3:0] dev_io_out;
    logic [3:0] dev_io_oe;
    wire [3:0] io_level;
    // undriven lines float high through the board pull-ups
    assign io_level = (host_io_oe & host_io_out) | (~host_io_oe & dev_io_oe & dev_io_out)
        | ~(host_io_oe | dev_io_oe);
    modport host (output cs_n, sclk, host_io_out, host_io_oe, input io_level);
    modport device (input cs_n, sclk, io_level, output dev_io_out, dev_io_oe);
endinterface : flash_link_if

// ===== logic/flash_dev_end.sv
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - lock-down protect pair reverts on power cycle
// - quad enable turns protect/pause pins into data
// - lock bits default zero, set once forever; here a reset (power cycle) clears them
// - suspend sets erase or program flag
// - resume, reset pair, power cycle clear flags
// - complement bit defaults zero, joins protect field; here nothing reads it but the status word
// - dual io read: 4 or 8 dummies
// - quad io read: 6 or 10 dummies
// - two-bit drive strength code, default 75 percent
// - msb first from first rising edge
// - opcode byte first, then optional address/data
// - host releases select after last bit
// - read-type commands get data-out phase
// - select rise ends output at any bit
// - write-type commands need whole byte count
// - partial program byte: nothing, latch stays
// - decode write enable, volatile enable, disable
// - table read: address, dummy, endless stream
// - release opcode: alone wakes, with dummies id
// - busy flag high during internal cycle
module flash_dev_end
    import flash_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    flash_link_if.device link,
    output logic [23:0] status_word_out,
    output logic [1:0] drive_strength_out
);
    typedef enum {PH_OP, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_SKIP} phase_t;

    logic [5:0] pin_s1, pin_s2, pin_s3;
    phase_t phase;
    logic [7:0] opcode, out_sh;
    logic [23:0] sh, addr;
    logic [4:0] cnt, din_cnt;
    logic [2:0] bitmod;
    logic [3:0] obits;
    logic [1:0] srp, drv, busy_kind;
    logic [4:0] bp;
    logic [2:0] lock;
    logic qe, cmp, dc, sus_e, sus_p, write_enable_latch, vwen, pd, rst_armed;
    logic [7:0] busy_cnt;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_s1 <= 6'h2f;
            pin_s2 <= 6'h2f;
            pin_s3 <= 6'h2f;
        end else begin
            pin_s1 <= {link.cs_n, link.sclk, link.io_level};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    wire hold_act = ~qe & ~pin_s2[3];
    wire wp_low = ~qe & ~pin_s2[2];
    wire cs_high = pin_s2[5];
    wire cs_rise = pin_s2[5] & ~pin_s3[5];
    wire sck_rise = ~cs_high & ~hold_act & pin_s2[4] & ~pin_s3[4];
    wire sck_fall = ~cs_high & ~hold_act & ~pin_s2[4] & pin_s3[4];
    wire write_in_progress = (busy_cnt != 8'h00) & ~sus_e & ~sus_p;
    wire [23:0] status = {1'b0, drv, 4'h0, dc, sus_e, cmp, lock, sus_p, qe, srp[1], srp[0],
        bp, write_enable_latch, write_in_progress};

    function automatic logic [2:0] in_w(input logic [7:0] op, input phase_t ph);
        if (ph == PH_ADDR || ph == PH_DUMMY) begin
            in_w = (op == OP_DIO) ? 3'd2 : (op == OP_QIO) ? 3'd4 : 3'd1;
        end else begin
            in_w = 3'd1;
        end
    endfunction : in_w

    function automatic logic [4:0] addr_clks(input logic [7:0] op);
        addr_clks = (op == OP_DIO) ? DIO_ADDR_CLKS : (op == OP_QIO) ? QIO_ADDR_CLKS : ADDR_CLKS;
    endfunction : addr_clks

    function automatic logic [4:0] dummy_clks(input logic [7:0] op, input logic dcb);
        case (op)
            OP_FREAD, OP_DREAD, OP_QREAD, OP_TABLE: dummy_clks = DUMMY_BYTE_CLKS;
            OP_DIO: dummy_clks = dcb ? DIO_DUMMY_HI : DIO_DUMMY_LO;
            OP_QIO: dummy_clks = dcb ? QIO_DUMMY_HI : QIO_DUMMY_LO;
            OP_RDPD: dummy_clks = ID_DUMMY_CLKS;
            default: dummy_clks = 5'h00;
        endcase
    endfunction : dummy_clks

    function automatic phase_t first_phase(input logic [7:0] op, input logic q);
        case (op)
            OP_READ, OP_FREAD, OP_DREAD, OP_DIO, OP_PP, OP_SE, OP_BE32, OP_BE64,
            OP_TABLE: first_phase = PH_ADDR;
            OP_QREAD, OP_QIO: first_phase = q ? PH_ADDR : PH_SKIP;
            OP_RDSR1, OP_RDSR2, OP_RDSR3: first_phase = PH_DOUT;
            OP_RDPD: first_phase = PH_DUMMY;
            OP_WREN, OP_VWREN, OP_WRDI, OP_WRSR1, OP_WRSR2, OP_WRSR3, OP_DPD, OP_CE1,
            OP_CE2, OP_SUSP, OP_RESM, OP_RSTEN, OP_RST: first_phase = PH_DIN;
            default: first_phase = PH_SKIP;
        endcase
    endfunction : first_phase

    wire [7:0] op_now = {sh[6:0], pin_s2[0]};
    wire busy_ok = (op_now == OP_RDSR1) | (op_now == OP_RDSR2) | (op_now == OP_RDSR3)
        | (op_now == OP_SUSP) | (op_now == OP_RESM) | (op_now == OP_RSTEN) | (op_now == OP_RST);
    phase_t op_phase;
    assign op_phase = (pd & (op_now != OP_RDPD)) | (write_in_progress & ~busy_ok) ? PH_SKIP
        : first_phase(op_now, qe);
    wire [2:0] iw = in_w(opcode, phase);
    wire [2:0] ow = (opcode == OP_DREAD || opcode == OP_DIO) ? 3'd2
        : (opcode == OP_QREAD || opcode == OP_QIO) ? 3'd4 : 3'd1;
    wire [23:0] sh_next = (iw == 3'd4) ? {sh[19:0], pin_s2[3:0]}
        : (iw == 3'd2) ? {sh[21:0], pin_s2[1:0]} : {sh[22:0], pin_s2[0]};
    wire [4:0] dum = dummy_clks(opcode, dc);
    wire [4:0] lim = (phase == PH_ADDR) ? addr_clks(opcode) : dum;
    wire phase_done = (cnt == lim - 5'd1);
    wire [7:0] table_byte = (addr[23:2] != 22'h0) ? ERASED_BYTE
        : (addr[1:0] == 2'h0) ? 8'h53 : (addr[1:0] == 2'h1) ? 8'h46
        : (addr[1:0] == 2'h2) ? 8'h44 : 8'h50;
    wire [7:0] next_byte = (opcode == OP_RDSR1) ? status[7:0]
        : (opcode == OP_RDSR2) ? status[15:8] : (opcode == OP_RDSR3) ? status[23:16]
        : (opcode == OP_RDPD) ? DEVICE_ID : (opcode == OP_TABLE) ? table_byte : ERASED_BYTE;

    // link sequencer
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phase <= PH_OP;
            opcode <= 8'h00;
            sh <= 24'h0;
            addr <= 24'h0;
            cnt <= 5'h0;
            din_cnt <= 5'h0;
            bitmod <= 3'h0;
            out_sh <= 8'h00;
            obits <= 4'h0;
        end else if (cs_high) begin
            phase <= PH_OP;
            cnt <= 5'h0;
            din_cnt <= 5'h0;
            bitmod <= 3'h0;
            obits <= 4'h0;
        end else if (sck_rise) begin
            sh <= sh_next;
            bitmod <= bitmod + 3'h1;
            cnt <= cnt + 5'h1;
            case (phase)
                PH_OP: if (cnt == 5'h7) begin
                    opcode <= op_now;
                    phase <= op_phase;
                    cnt <= 5'h0;
                end
                PH_ADDR: if (phase_done) begin
                    addr <= sh_next;
                    cnt <= 5'h0;
                    phase <= (dum != 5'h0) ? PH_DUMMY : (opcode == OP_READ) ? PH_DOUT : PH_DIN;
                end
                PH_DUMMY: if (phase_done) begin
                    phase <= PH_DOUT;
                end
                PH_DIN: if (din_cnt != 5'h1f) begin
                    din_cnt <= din_cnt + 5'h1;
                end
                default: ;
            endcase
        end else if (sck_fall && phase == PH_DOUT) begin
            if (obits <= 4'(ow)) begin
                out_sh <= next_byte;
                obits <= 4'h8;
                addr <= addr + 24'h1;
            end else begin
                out_sh <= out_sh << ow;
                obits <= obits - 4'(ow);
            end
        end
    end

    wire drive_on = (phase == PH_DOUT) & ~cs_high & ~hold_act & (obits != 4'h0);
    wire [3:0] pin_val = (ow == 3'd4) ? out_sh[7:4] : (ow == 3'd2) ? {2'b00, out_sh[7:6]}
        : {2'b00, out_sh[7], 1'b0};
    wire [3:0] pin_oe = ~drive_on ? 4'h0 : (ow == 3'd4) ? 4'hf : (ow == 3'd2) ? 4'h3 : 4'h2;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            link.dev_io_out <= 4'h0;
            link.dev_io_oe <= 4'h0;
            status_word_out <= 24'h0;
            drive_strength_out <= DRV_RESET;
        end else begin
            link.dev_io_out <= pin_val;
            link.dev_io_oe <= pin_oe;
            status_word_out <= status;
            drive_strength_out <= drv;
        end
    end

    // command execution on select release
    wire exec_ok = cs_rise & (phase != PH_OP) & (phase != PH_SKIP);
    wire whole = (bitmod == 3'h0);
    wire ex_w = exec_ok & whole;
    wire is_wrsr = (opcode == OP_WRSR1) | (opcode == OP_WRSR2) | (opcode == OP_WRSR3);
    wire sr_prot = (srp == SRP_LOCKDOWN) | (srp == 2'h3) | ((srp == SRP_HW) & wp_low);
    wire wr_len_ok = (din_cnt == DIN_BITS_ONE)
        | ((opcode == OP_WRSR1) & (din_cnt == DIN_BITS_TWO));
    wire wrsr_go = ex_w & is_wrsr & wr_len_ok & (write_enable_latch | vwen) & ~sr_prot;
    wire pp_go = ex_w & (opcode == OP_PP) & (phase == PH_DIN) & (din_cnt != 5'h0) & write_enable_latch;
    wire er_go = ex_w & (phase == PH_DIN) & write_enable_latch & ((opcode == OP_SE) | (opcode == OP_BE32)
        | (opcode == OP_BE64) | (opcode == OP_CE1) | (opcode == OP_CE2));
    wire wr_b1 = wrsr_go & (opcode == OP_WRSR1);
    wire wr_b2 = wrsr_go & ((opcode == OP_WRSR2) | (din_cnt == DIN_BITS_TWO));
    wire wr_b3 = wrsr_go & (opcode == OP_WRSR3);
    wire [7:0] b1 = (din_cnt == DIN_BITS_TWO) ? sh[15:8] : sh[7:0];
    wire busy_live = (busy_cnt != 8'h00) & ~sus_e & ~sus_p;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            srp <= SRP_SOFT;
            bp <= 5'h0;
            qe <= 1'b0;
            lock <= 3'h0;
            cmp <= 1'b0;
            dc <= 1'b0;
            drv <= DRV_RESET;
            sus_e <= 1'b0;
            sus_p <= 1'b0;
            write_enable_latch <= 1'b0;
            vwen <= 1'b0;
            pd <= 1'b0;
            rst_armed <= 1'b0;
            busy_cnt <= 8'h0;
            busy_kind <= K_WRSR;
        end else begin
            if (busy_live) begin
                busy_cnt <= busy_cnt - 8'h1;
                if (busy_cnt == 8'h1) begin
                    write_enable_latch <= 1'b0;
                end
            end
            if (exec_ok) begin
                vwen <= 1'b0;
                rst_armed <= 1'b0;
                if (opcode == OP_RDPD) begin
                    pd <= 1'b0;
                end
            end
            if (ex_w) begin
                case (opcode)
                    OP_WREN: write_enable_latch <= 1'b1;
                    OP_WRDI: write_enable_latch <= 1'b0;
                    OP_VWREN: vwen <= 1'b1;
                    OP_DPD: pd <= 1'b1;
                    OP_RSTEN: rst_armed <= 1'b1;
                    OP_SUSP: if (busy_cnt != 8'h0) begin
                        sus_e <= sus_e | (busy_kind == K_ERASE);
                        sus_p <= sus_p | (busy_kind == K_PROG);
                    end
                    OP_RESM: begin
                        sus_e <= 1'b0;
                        sus_p <= 1'b0;
                    end
                    OP_RST: if (rst_armed) begin
                        sus_e <= 1'b0;
                        sus_p <= 1'b0;
                        write_enable_latch <= 1'b0;
                        busy_cnt <= 8'h0;
                    end
                    default: ;
                endcase
            end
            if (wr_b1) begin
                srp[0] <= b1[ST_SRP_LO];
                bp <= b1[ST_BP_LO +: 5];
            end
            if (wr_b2) begin
                srp[1] <= sh[ST_SRP_HI - 8];
                qe <= sh[ST_QE - 8];
                lock <= lock | sh[ST_LOCK_LO - 8 +: 3];
                cmp <= sh[ST_CMP - 8];
            end
            if (wr_b3) begin
                dc <= sh[ST_DC - 16];
                drv <= sh[ST_DRV_LO - 16 +: 2];
            end
            if ((wrsr_go & write_enable_latch) | pp_go | er_go) begin
                busy_cnt <= BUSY_CYCLES;
                busy_kind <= pp_go ? K_PROG : er_go ? K_ERASE : K_WRSR;
            end
        end
    end
endmodule : flash_dev_end

// ===== logic/flash_host_end.sv
`timescale 1ns/1ps
module flash_host_end
    import flash_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [3:0] wb_sel_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    flash_link_if.host link
);
    typedef enum {H_IDLE, H_RUN, H_GAP} host_state_t;

    host_state_t state;
    logic [3:0] io_s1, io_s2, tmr;
    logic [31:0] tx_reg, tx_sh, rx;
    logic [16:0] ctrl;
    logic [6:0] idx, b2, b3, b4, b5;
    logic [4:0] gap;

    wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    wire wr_ctrl = wb_req & wb_we_in & (wb_adr_in == REG_CTRL);
    wire go = wr_ctrl & wb_dat_in[CF_GO] & (state == H_IDLE);
    wire [31:0] sel_mask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}},
        {8{wb_sel_in[0]}}};
    wire [1:0] aw_c = wb_dat_in[CF_AW + 1] ? 2'd2 : {1'b0, wb_dat_in[CF_AW]};
    wire [1:0] dw_c = wb_dat_in[CF_DW + 1] ? 2'd2 : {1'b0, wb_dat_in[CF_DW]};
    wire [6:0] n_addr = {2'b00, wb_dat_in[CF_TXB +: 2], 3'b000} >> aw_c;
    wire [6:0] n_rx = {1'b0, wb_dat_in[CF_RXB +: 3], 3'b000} >> dw_c;
    wire [6:0] g2 = 7'd8 + n_addr;
    wire [6:0] g3 = g2 + {4'h0, wb_dat_in[CF_XTRA +: 3]};
    wire [6:0] g4 = g3 + {3'h0, wb_dat_in[CF_DUM +: 4]};
    wire [1:0] caw = ctrl[CF_AW + 1] ? 2'd2 : {1'b0, ctrl[CF_AW]};
    wire [1:0] cdw = ctrl[CF_DW + 1] ? 2'd2 : {1'b0, ctrl[CF_DW]};
    // lane code: 0 single, 1 dual, 2 quad
    wire [1:0] cur_c = (idx < 7'd8) ? 2'd0 : (idx < b2) ? caw : (idx < b4) ? 2'd0 : cdw;
    wire sending = (state == H_RUN) & (idx < b3);
    wire [3:0] drv_val = (cur_c == 2'd2) ? tx_sh[31:28]
        : (cur_c == 2'd1) ? {2'b00, tx_sh[31:30]} : {3'b000, tx_sh[31]};
    wire [3:0] drv_oe = ~sending ? 4'h0 : (cur_c == 2'd2) ? 4'hf : (cur_c == 2'd1) ? 4'h3 : 4'h1;
    wire [31:0] rx_next = (cur_c == 2'd2) ? {rx[27:0], io_s2}
        : (cur_c == 2'd1) ? {rx[29:0], io_s2[1:0]} : {rx[30:0], io_s2[1]};
    wire [31:0] rd_val = (wb_adr_in == REG_CTRL) ? {15'h0, ctrl}
        : (wb_adr_in == REG_TX) ? tx_reg : (wb_adr_in == REG_RX) ? rx
        : (wb_adr_in == REG_STAT) ? {31'h0, state != H_IDLE} : 32'h0;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0;
            tx_reg <= 32'h0;
            io_s1 <= 4'hf;
            io_s2 <= 4'hf;
        end else begin
            wb_ack_out <= wb_req;
            wb_dat_out <= wb_req ? rd_val : 32'h0;
            if (wb_req & wb_we_in & (wb_adr_in == REG_TX)) begin
                tx_reg <= (tx_reg & ~sel_mask) | (wb_dat_in & sel_mask);
            end
            io_s1 <= link.io_level;
            io_s2 <= io_s1;
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= H_IDLE;
            link.cs_n <= 1'b1;
            link.sclk <= 1'b0;
            link.host_io_out <= 4'h0;
            link.host_io_oe <= 4'h0;
            ctrl <= 17'h0;
            tx_sh <= 32'h0;
            rx <= 32'h0;
            tmr <= 4'h0;
            idx <= 7'h0;
            {b2, b3, b4, b5} <= 28'h0;
            gap <= 5'h0;
        end else begin
            link.host_io_out <= drv_val;
            link.host_io_oe <= drv_oe;
            if (wr_ctrl) begin
                ctrl <= {1'b0, wb_dat_in[15:0]};
            end
            case (state)
                H_IDLE: if (go) begin
                    state <= H_RUN;
                    link.cs_n <= 1'b0;
                    tx_sh <= tx_reg;
                    // stale bytes from the last frame would sit above the new ones
                    rx <= 32'h0;
                    tmr <= SCLK_HALF - 4'h1;
                    idx <= 7'h0;
                    {b2, b3, b4} <= {g2, g3, g4};
                    b5 <= g4 + n_rx;
                end
                H_RUN: if (tmr != 4'h0) begin
                    tmr <= tmr - 4'h1;
                end else begin
                    tmr <= SCLK_HALF - 4'h1;
                    link.sclk <= ~link.sclk;
                    if (!link.sclk && idx >= b4) begin
                        rx <= rx_next;
                    end
                    if (link.sclk) begin
                        tx_sh <= tx_sh << (1 << cur_c);
                        idx <= idx + 7'h1;
                        if (idx == b5 - 7'h1) begin
                            link.cs_n <= 1'b1;
                            state <= H_GAP;
                            gap <= {SCLK_HALF, 1'b0};
                        end
                    end
                end
                H_GAP: if (gap != 5'h0) begin
                    gap <= gap - 5'h1;
                end else begin
                    state <= H_IDLE;
                end
                default: state <= H_IDLE;
            endcase
        end
    end
endmodule : flash_host_end

// ===== sim/flash_link_sva.sv
`timescale 1ns/1ps
module flash_link_sva (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] host_io_out,
    input wire logic [3:0] host_io_oe,
    input wire logic [3:0] dev_io_out,
    input wire logic [3:0] dev_io_oe
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_IDLE_LOW: assert property (cs_n |-> !sclk)
        else $error("serial clock moves while deselected");
    AST_FIRST_EDGE: assert property ($fell(cs_n) |-> !sclk ##[1:40] sclk)
        else $error("no rising serial edge after select");
    AST_HIGH_HALF: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
        else $error("serial clock high phase wrong");
    AST_LOW_HALF: assert property ($fell(sclk) |-> !sclk[*8])
        else $error("serial clock low phase too short");
    AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n[*8])
        else $error("select gap too short");
    AST_HOST_HOLD: assert property (sclk && $past(sclk) |-> $stable(host_io_out))
        else $error("host data moved while clock high");
    AST_DEV_HOLD: assert property (sclk && $past(sclk) && dev_io_oe != 4'h0
        |-> $stable(dev_io_out))
        else $error("device data moved while clock high");
    AST_DEV_RELEASE: assert property ($rose(cs_n) |-> ##[0:5] dev_io_oe == 4'h0)
        else $error("device kept driving after deselect");
    AST_DEV_QUIET: assert property (cs_n[*6] |-> dev_io_oe == 4'h0)
        else $error("device drives while deselected");
    COV_FRAME: cover property ($fell(cs_n));
    COV_DEV_OUT: cover property ($rose(dev_io_oe[1]));
    COV_CUT: cover property ($rose(cs_n) && dev_io_oe != 4'h0);
endmodule : flash_link_sva

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import flash_pkg::*;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wb_cyc_in = 1'b0;
    logic wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0;
    logic [3:0] wb_adr_in = 4'h0;
    logic [3:0] wb_sel_in = 4'hf;
    logic [31:0] wb_dat_in = 32'h0;
    logic [31:0] wb_dat_out, rd;
    logic wb_ack_out;
    logic [23:0] status_word_out;
    logic [1:0] drive_strength_out, d;
    int n_fail = 0;
    int checks_done = 0;
    flash_link_if link_if ();
    flash_host_end flash_host_end_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in), .wb_sel_in(wb_sel_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .link(link_if.host));
    flash_dev_end flash_dev_end_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .link(link_if.device), .status_word_out(status_word_out),
        .drive_strength_out(drive_strength_out));
    flash_link_sva flash_link_sva_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .cs_n(link_if.cs_n), .sclk(link_if.sclk), .host_io_out(link_if.host_io_out),
        .host_io_oe(link_if.host_io_oe), .dev_io_out(link_if.dev_io_out),
        .dev_io_oe(link_if.dev_io_oe));
    always #5 sys_clk_in = ~sys_clk_in;
    task automatic end_of_test;
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // ack is read before the edge's own update lands, so it is the sampled value
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        @(posedge sys_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= adr;
        wb_dat_in <= dat;
        do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
        rd = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask : wb
    function automatic logic [31:0] cf(input int nb, input int nrx, input int xtra);
        return 32'((nb << CF_TXB) | (nrx << CF_RXB) | (xtra << CF_XTRA) | (1 << CF_GO));
    endfunction : cf
    function automatic logic [31:0] sr3(input logic [1:0] drv);
        return {24'h0, 1'b0, drv, 5'h0};
    endfunction : sr3
    task automatic xfer(input logic [7:0] op, input logic [23:0] tx, input logic [31:0] ctrl);
        wb(1'b1, REG_TX, {op, tx});
        wb(1'b1, REG_CTRL, ctrl);
        repeat (4) @(posedge sys_clk_in);
        do wb(1'b0, REG_STAT, 32'h0); while (rd[0] !== 1'b0);
        repeat (32) @(posedge sys_clk_in);
        wb(1'b0, REG_RX, 32'h0);
    endtask : xfer
    task automatic wait_idle;
        do xfer(OP_RDSR1, 24'h0, cf(0, 1, 0)); while (rd[0] !== 1'b0);
    endtask : wait_idle
    task automatic wr_status(input logic [7:0] op, input logic [23:0] tx, input int nb);
        xfer(OP_WREN, 24'h0, cf(0, 0, 0));
        xfer(op, tx, cf(nb, 0, 0));
        wait_idle();
    endtask : wr_status
    task automatic do_reset;
        @(posedge sys_clk_in);
        sys_rst_in <= 1'b1;
        repeat (6) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
    endtask : do_reset
    initial begin
        void'($urandom(32'h588c));
        do_reset();
        check({8'h0, status_word_out}, 32'h400000);
        check({30'h0, drive_strength_out}, {30'h0, DRV_RESET});
        xfer(OP_RDSR3, 24'h0, cf(0, 1, 0));
        check(rd, sr3(DRV_RESET));
        xfer(OP_RDSR2, 24'h0, cf(0, 1, 0));
        check(rd, 32'h0);
        xfer(OP_WREN, 24'h0, cf(0, 0, 3));
        check({31'h0, status_word_out[1]}, 32'h0);
        xfer(OP_WREN, 24'h0, cf(0, 0, 0));
        check({31'h0, status_word_out[1]}, 32'h1);
        xfer(8'hff, 24'h0, cf(0, 1, 0));
        check(rd, 32'hff);
        xfer(OP_WRDI, 24'h0, cf(0, 0, 0));
        check({31'h0, status_word_out[1]}, 32'h0);
        xfer(OP_VWREN, 24'h0, cf(0, 0, 0));
        check({31'h0, status_word_out[1]}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 2'h0 : 2'($urandom);
            wr_status(OP_WRSR3, {1'b0, d, 5'h0, 16'h0}, 1);
            check({30'h0, drive_strength_out}, {30'h0, d});
            xfer(OP_RDSR3, 24'h0, cf(0, 1, 0));
            check(rd, sr3(d));
        end
        wr_status(OP_WRSR2, 24'h0a0000, 1);
        check({24'h0, status_word_out[15:8]}, 32'h0a);
        wr_status(OP_WRSR2, 24'h020000, 1);
        check({24'h0, status_word_out[15:8]}, 32'h0a);
        wr_status(OP_WRSR1, 24'h000b00, 2);
        check({30'h0, status_word_out[8:7]}, 32'h2);
        do_reset();
        check({8'h0, status_word_out}, 32'h400000);
        end_of_test();
    end
    initial begin
        #900us;
        n_fail++;
        end_of_test();
    end
endmodule : testbench
